// ==== rtl/eeba_pkg.sv ====
// Shared constants for the EEPROM byte access control, both ends
package eeba_pkg;
  // ----------------------------------------
  // I/O register offsets seen by the core
  // ----------------------------------------
  localparam logic [5:0] CTRL_OFS = 6'h1F;
  localparam logic [5:0] DATA_OFS = 6'h20;
  localparam logic [5:0] ALO_OFS = 6'h21;
  localparam logic [5:0] AHI_OFS = 6'h22;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int RD_BIT = 0;
  localparam int WS_BIT = 1;
  localparam int ARM_BIT = 2;
  localparam int RIE_BIT = 3;
  localparam int PM_LO = 4;
  localparam logic [1:0] PM_ATOMIC = 2'h0;
  localparam logic [1:0] PM_ERASE = 2'h1;
  localparam logic [1:0] PM_WRITE = 2'h2;
  localparam logic [1:0] PM_RSVD = 2'h3;
  localparam logic [1:0] PM_RESET = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] WR_HALT = 3'h2;
  localparam logic [2:0] RD_HALT = 3'h4;
  localparam int ATOMIC_TIME_US = 3400;
  localparam int SPLIT_TIME_US = 1800;
  localparam int RC_WRITE_CYCLES = 26368;
  // ----------------------------------------
  // Controller APB map
  // ----------------------------------------
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] ADDR_OFS = 8'h04;
  localparam logic [7:0] WDAT_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] CFG_OFS = 8'h10;
endpackage

// ==== rtl/eeba_if.sv ====
// Core-side I/O register port between the EEPROM control and its core
`timescale 1ns/100ps
`default_nettype none
interface eeba_if;
  logic [5:0] io_addr;
  logic io_we;
  logic io_re;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic cpu_halt;
  logic ready_irq;
  logic global_irq_en;
  logic self_prog_active;
  modport dev (input io_addr, io_we, io_re, io_wdata, global_irq_en, self_prog_active,
               output io_rdata, cpu_halt, ready_irq);
  modport core (output io_addr, io_we, io_re, io_wdata, global_irq_en, self_prog_active,
                input io_rdata, cpu_halt, ready_irq);
endinterface
`default_nettype wire

// ==== rtl/eeba_dev.sv ====
// EEPROM byte access control: address, data and control registers with the array
`timescale 1ns/100ps
`default_nettype none
module eeba_dev #(
  parameter int WR_RC_CYCLES = eeba_pkg::RC_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Core reset and calibrated oscillator tick
  input wire logic core_rst,
  input wire logic rc_tick,
  // Core side
  eeba_if.dev bus
);
  localparam int SPLIT_CYCLES = WR_RC_CYCLES * eeba_pkg::SPLIT_TIME_US / eeba_pkg::ATOMIC_TIME_US;
  localparam logic [14:0] ATOMIC_CNT = 15'(WR_RC_CYCLES);
  localparam logic [14:0] SPLIT_CNT = 15'(SPLIT_CYCLES);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] mem [0:1023];
  logic [9:0] addr_q;
  logic [7:0] data_q;
  logic [1:0] mode_q;
  logic rie_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;
  logic ws_q;
  logic [14:0] prog_cnt_q;
  logic [2:0] halt_cnt_q;
  logic cpu_halt_q;
  logic irq_q;
  logic [7:0] rdata_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic wr_ctrl = bus.io_we && bus.io_addr == eeba_pkg::CTRL_OFS;
  wire logic wr_data = bus.io_we && bus.io_addr == eeba_pkg::DATA_OFS;
  wire logic wr_alo = bus.io_we && bus.io_addr == eeba_pkg::ALO_OFS && !ws_q;
  wire logic wr_ahi = bus.io_we && bus.io_addr == eeba_pkg::AHI_OFS && !ws_q;
  wire logic set_arm = wr_ctrl && bus.io_wdata[eeba_pkg::ARM_BIT];
  wire logic set_ws = wr_ctrl && bus.io_wdata[eeba_pkg::WS_BIT];
  // Flash self-programming and a running write both lock out a new start
  wire logic start = set_ws && arm_q && !ws_q && !bus.self_prog_active;
  wire logic rd_go = wr_ctrl && bus.io_wdata[eeba_pkg::RD_BIT] && !ws_q;
  wire logic rsvd = mode_q == eeba_pkg::PM_RSVD;
  wire logic prog_done = ws_q && (rsvd || (prog_cnt_q == 15'h0000));
  wire logic [1:0] mode_in = bus.io_wdata[eeba_pkg::PM_LO +: 2];
  wire logic [14:0] prog_load = (mode_in == eeba_pkg::PM_ATOMIC) ? ATOMIC_CNT : SPLIT_CNT;
  wire logic [7:0] ctrl_rd = {2'b00, mode_q, rie_q, arm_q, ws_q, 1'b0};
  wire logic [7:0] cur_byte = mem[addr_q];

  // Byte left in the array for each mode; write only can just clear bits
  function automatic logic [7:0] prog_byte(input logic [1:0] m, input logic [7:0] old, input logic [7:0] d);
    unique case (m)
      eeba_pkg::PM_ATOMIC: prog_byte = d;
      eeba_pkg::PM_ERASE: prog_byte = eeba_pkg::ERASED_BYTE;
      eeba_pkg::PM_WRITE: prog_byte = old & d;
      eeba_pkg::PM_RSVD: prog_byte = old;
    endcase
  endfunction

  wire logic [7:0] rd_mux =
    (bus.io_addr == eeba_pkg::CTRL_OFS) ? ctrl_rd :
    (bus.io_addr == eeba_pkg::DATA_OFS) ? data_q :
    (bus.io_addr == eeba_pkg::ALO_OFS) ? addr_q[7:0] :
    (bus.io_addr == eeba_pkg::AHI_OFS) ? {6'b00_0000, addr_q[9:8]} : 8'h00;

  // ----------------------------------------
  // Array and address: no reset, contents undefined until written
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (clk_en && prog_done && !rsvd) begin
      mem[addr_q] <= prog_byte(mode_q, cur_byte, data_q);
    end
  end

  always_ff @(posedge pclk) begin
    if (clk_en && wr_alo) begin
      addr_q[7:0] <= bus.io_wdata;
    end
    if (clk_en && wr_ahi) begin
      addr_q[9:8] <= bus.io_wdata[1:0];
    end
  end

  // ----------------------------------------
  // Data register
  // ----------------------------------------
  // The core must not touch data during a write; the array takes data_q at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= 8'h00;
    end else if (clk_en) begin
      if (rd_go) begin
        data_q <= cur_byte;
      end else if (wr_data) begin
        data_q <= bus.io_wdata;
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= eeba_pkg::PM_RESET;
      rie_q <= 1'b0;
    end else if (clk_en) begin
      if (core_rst) begin
        rie_q <= 1'b0;
        if (!ws_q) begin
          mode_q <= eeba_pkg::PM_RESET;
        end
      end else if (wr_ctrl) begin
        rie_q <= bus.io_wdata[eeba_pkg::RIE_BIT];
        if (!ws_q) begin
          mode_q <= mode_in;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else if (clk_en) begin
      if (core_rst) begin
        arm_q <= 1'b0;
      end else if (set_arm) begin
        arm_q <= 1'b1;
        arm_cnt_q <= eeba_pkg::ARM_CYCLES - 3'h1;
      end else if (arm_q) begin
        arm_cnt_q <= arm_cnt_q - 3'h1;
        if (arm_cnt_q == 3'h0) begin
          arm_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Write sequencing, timed by oscillator ticks
  // ----------------------------------------
  // A running write is not abandoned by a core reset; only power-on reset stops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_q <= 1'b0;
      prog_cnt_q <= 15'h0000;
    end else if (clk_en) begin
      if (start) begin
        ws_q <= 1'b1;
        prog_cnt_q <= prog_load - 15'h0001;
      end else if (prog_done) begin
        ws_q <= 1'b0;
      end else if (ws_q && rc_tick) begin
        prog_cnt_q <= prog_cnt_q - 15'h0001;
      end
    end
  end

  // ----------------------------------------
  // Core halt, interrupt and read data
  // ----------------------------------------
  wire logic [2:0] halt_d =
    start ? eeba_pkg::WR_HALT :
    rd_go ? eeba_pkg::RD_HALT :
    (halt_cnt_q != 3'h0) ? halt_cnt_q - 3'h1 : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_cnt_q <= 3'h0;
      cpu_halt_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      halt_cnt_q <= halt_d;
      cpu_halt_q <= halt_d != 3'h0;
      irq_q <= rie_q && bus.global_irq_en && !ws_q && !bus.self_prog_active;
      if (bus.io_re) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign bus.io_rdata = rdata_q;
  assign bus.cpu_halt = cpu_halt_q;
  assign bus.ready_irq = irq_q;
endmodule
`default_nettype wire

// ==== rtl/eeba_ctl.sv ====
// Core-side controller: APB registers that drive the EEPROM write and read procedures
`timescale 1ns/100ps
`default_nettype none
module eeba_ctl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash self-programming state
  input wire logic self_prog_busy,
  // Device side
  eeba_if.core bus
);
  typedef enum logic [3:0] {
    S_IDLE, S_POLL, S_PWAIT, S_PCHK, S_ALO, S_AHI, S_DAT, S_ARM, S_STB,
    S_RSTB, S_HGAP, S_HWAIT, S_GET, S_GWAIT, S_GCAP
  } eeba_st_e;
  eeba_st_e st_q;
  logic is_rd_q, gie_q, rie_q, pready_q, we_q, re_q, spa_q;
  logic [1:0] mode_q;
  logic [9:0] addr_q;
  logic [7:0] wdat_q, rbyte_q, io_wd_q;
  logic [5:0] io_a_q;
  logic [31:0] prdata_q;

  // ----------------------------------------
  // APB decode, one wait-free access phase
  // ----------------------------------------
  wire logic setup = psel && !penable;
  wire logic wr_acc = psel && penable && pready_q && pwrite;
  wire logic idle = st_q == S_IDLE;
  wire logic go_wr = wr_acc && paddr == eeba_pkg::CMD_OFS && pwdata[0] && idle;
  wire logic go_rd = wr_acc && paddr == eeba_pkg::CMD_OFS && pwdata[1] && idle;
  wire logic [7:0] cfg_byte = {4'h0, mode_q, rie_q, gie_q};
  wire logic [7:0] ctrl_byte = {2'b00, mode_q, rie_q, 3'b000};
  wire logic [31:0] rd_mux =
    (paddr == eeba_pkg::ADDR_OFS) ? {22'h00_0000, addr_q} :
    (paddr == eeba_pkg::WDAT_OFS) ? {24'h00_0000, wdat_q} :
    (paddr == eeba_pkg::STAT_OFS) ? {16'h0000, rbyte_q, 5'h00, bus.ready_irq, bus.cpu_halt, !idle} :
    (paddr == eeba_pkg::CFG_OFS) ? {24'h00_0000, cfg_byte} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      gie_q <= 1'b0;
      rie_q <= 1'b0;
      mode_q <= eeba_pkg::PM_RESET;
      addr_q <= 10'h000;
      wdat_q <= 8'h00;
    end else if (clk_en) begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= rd_mux;
      end
      if (wr_acc && paddr == eeba_pkg::CFG_OFS) begin
        {mode_q, rie_q, gie_q} <= pwdata[3:0];
      end
      // Operands are frozen while a procedure runs so the sequence stays coherent
      if (wr_acc && paddr == eeba_pkg::ADDR_OFS && idle) begin
        addr_q <= pwdata[9:0];
      end
      if (wr_acc && paddr == eeba_pkg::WDAT_OFS && idle) begin
        wdat_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Procedure sequencer
  // ----------------------------------------
  // Arm and strobe go out on adjacent cycles, well inside the arm window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      is_rd_q <= 1'b0;
      we_q <= 1'b0;
      re_q <= 1'b0;
      io_a_q <= 6'h00;
      io_wd_q <= 8'h00;
      rbyte_q <= 8'h00;
      spa_q <= 1'b0;
    end else if (clk_en) begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      spa_q <= self_prog_busy;
      unique case (st_q)
        S_IDLE: begin
          if (go_wr || go_rd) begin
            is_rd_q <= go_rd;
            st_q <= S_POLL;
          end
        end
        S_POLL: begin
          re_q <= 1'b1;
          io_a_q <= eeba_pkg::CTRL_OFS;
          st_q <= S_PWAIT;
        end
        S_PWAIT: st_q <= S_PCHK;
        S_PCHK: begin
          if (bus.io_rdata[eeba_pkg::WS_BIT] || (!is_rd_q && spa_q)) begin
            st_q <= S_POLL;
          end else begin
            st_q <= S_ALO;
          end
        end
        S_ALO: begin
          we_q <= 1'b1;
          io_a_q <= eeba_pkg::ALO_OFS;
          io_wd_q <= addr_q[7:0];
          st_q <= S_AHI;
        end
        S_AHI: begin
          we_q <= 1'b1;
          io_a_q <= eeba_pkg::AHI_OFS;
          io_wd_q <= {6'b00_0000, addr_q[9:8]};
          st_q <= is_rd_q ? S_RSTB : S_DAT;
        end
        S_DAT: begin
          we_q <= 1'b1;
          io_a_q <= eeba_pkg::DATA_OFS;
          io_wd_q <= wdat_q;
          st_q <= S_ARM;
        end
        S_ARM: begin
          we_q <= 1'b1;
          io_a_q <= eeba_pkg::CTRL_OFS;
          io_wd_q <= ctrl_byte | (8'h01 << eeba_pkg::ARM_BIT);
          st_q <= S_STB;
        end
        S_STB: begin
          we_q <= 1'b1;
          io_wd_q <= ctrl_byte | (8'h01 << eeba_pkg::WS_BIT);
          st_q <= S_HGAP;
        end
        S_RSTB: begin
          we_q <= 1'b1;
          io_a_q <= eeba_pkg::CTRL_OFS;
          io_wd_q <= ctrl_byte | (8'h01 << eeba_pkg::RD_BIT);
          st_q <= S_HGAP;
        end
        S_HGAP: st_q <= S_HWAIT;
        S_HWAIT: begin
          if (!bus.cpu_halt) begin
            st_q <= is_rd_q ? S_GET : S_IDLE;
          end
        end
        S_GET: begin
          re_q <= 1'b1;
          io_a_q <= eeba_pkg::DATA_OFS;
          st_q <= S_GWAIT;
        end
        S_GWAIT: st_q <= S_GCAP;
        S_GCAP: begin
          rbyte_q <= bus.io_rdata;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Interrupts stay with software; the procedure never opens the global enable itself
  assign bus.global_irq_en = gie_q;
  assign bus.self_prog_active = spa_q;
  assign bus.io_addr = io_a_q;
  assign bus.io_we = we_q;
  assign bus.io_re = re_q;
  assign bus.io_wdata = io_wd_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = 1'b0;
endmodule
`default_nettype wire

// ==== bench/eeba_monitor.sv ====
// Concurrent checks on the core-side port between the EEPROM control and its controller
`timescale 1ns/100ps
`default_nettype none
module eeba_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core-side port
  input wire logic [5:0] io_addr,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic cpu_halt,
  input wire logic ready_irq,
  input wire logic global_irq_en,
  input wire logic self_prog_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  wire logic ctl_wr = io_we && io_addr == eeba_pkg::CTRL_OFS;
  wire logic ctl_rd = io_re && io_addr == eeba_pkg::CTRL_OFS;
  logic [2:0] arm_age_q;
  logic [7:0] wr_age_q;
  logic halt_q;
  logic rd_stb_q;
  // Ages saturate so a long idle never wraps back into a live window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_age_q <= 3'h7;
      wr_age_q <= 8'hFF;
      halt_q <= 1'b0;
      rd_stb_q <= 1'b0;
    end else begin
      if (ctl_wr && io_wdata[eeba_pkg::ARM_BIT]) begin
        arm_age_q <= 3'h0;
      end else if (arm_age_q != 3'h7) begin
        arm_age_q <= arm_age_q + 3'h1;
      end
      if (cpu_halt && !halt_q && !rd_stb_q) begin
        wr_age_q <= 8'h00;
      end else if (wr_age_q != 8'hFF) begin
        wr_age_q <= wr_age_q + 8'h01;
      end
      halt_q <= cpu_halt;
      rd_stb_q <= ctl_wr && io_wdata[eeba_pkg::RD_BIT];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ctrl_rsvd_zero: assert property (ctl_rd |=> io_rdata[7:6] == 2'h0 && !io_rdata[0])
    else $error("control read shows reserved or read bit set");
  a_arm_expires: assert property (ctl_rd && arm_age_q >= 3'h4 |=> !io_rdata[eeba_pkg::ARM_BIT])
    else $error("arm bit still set after four cycles");
  a_halt_cause: assert property ($rose(cpu_halt) |-> $past(ctl_wr) && $past(io_wdata[1:0]) != 2'h0)
    else $error("core halted without a strobe write");
  a_wr_halt_len: assert property ($rose(cpu_halt) && !rd_stb_q |-> cpu_halt[*2] ##1 !cpu_halt)
    else $error("write halt is not two cycles");
  a_rd_halt_len: assert property ($rose(cpu_halt) && rd_stb_q |-> cpu_halt[*4] ##1 !cpu_halt)
    else $error("read halt is not four cycles");
  a_irq_gie_off: assert property ((!global_irq_en)[*3] |-> !ready_irq)
    else $error("ready interrupt with global enable off");
  a_irq_spm_off: assert property (self_prog_active[*3] |-> !ready_irq)
    else $error("ready interrupt during self-programming");
  a_strobe_done: assert property (ctl_rd && wr_age_q >= 8'hE6 |=> !io_rdata[eeba_pkg::WS_BIT])
    else $error("write strobe not cleared after programming time");
  a_strobe_armed: assert property ($rose(cpu_halt) && !rd_stb_q |-> arm_age_q <= 3'h4)
    else $error("write started without a recent arm");
endmodule
`default_nettype wire

// ==== bench/eeba_tb.sv ====
// Self-checking bench: APB-driven controller joined to the EEPROM control
`timescale 1ns/100ps
`default_nettype none
module eeba_tb;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  // Short write count keeps the run brief; split modes scale to 105
  localparam int WR_CYC = 200;
  logic pclk, presetn, clk_en, core_rst, rc_tick, self_prog_busy;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int n_mismatch, samples_checked, cyc;
  logic [1:0] md [4] = '{eeba_pkg::PM_ATOMIC, eeba_pkg::PM_ERASE, eeba_pkg::PM_WRITE, eeba_pkg::PM_RSVD};
  logic [7:0] wd [4] = '{8'hA5, 8'h00, 8'h3C, 8'h00};
  int lo [4] = '{150, 60, 60, 0};
  int hi [4] = '{260, 150, 150, 60};
  eeba_if bus_if ();
  eeba_dev #(.WR_RC_CYCLES(WR_CYC)) i_eeba_dev (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .core_rst(core_rst), .rc_tick(rc_tick), .bus(bus_if));
  eeba_ctl i_eeba_ctl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .self_prog_busy(self_prog_busy), .bus(bus_if));
  eeba_monitor i_eeba_monitor (.pclk(pclk), .presetn(presetn), .io_addr(bus_if.io_addr), .io_we(bus_if.io_we),
    .io_re(bus_if.io_re), .io_wdata(bus_if.io_wdata), .io_rdata(bus_if.io_rdata), .cpu_halt(bus_if.cpu_halt),
    .ready_irq(bus_if.ready_irq), .global_irq_en(bus_if.global_irq_en),
    .self_prog_active(bus_if.self_prog_active));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One transfer, then an idle cycle so no signal is driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_mismatch++;
      tally_and_finish();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(q & m, e);
  endtask
  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      apb(1'b0, eeba_pkg::STAT_OFS, 32'h0000_0000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic ee_write(input logic [9:0] a, input logic [7:0] d);
    wr(eeba_pkg::ADDR_OFS, {22'h00_0000, a});
    wr(eeba_pkg::WDAT_OFS, {24'h00_0000, d});
    wr(eeba_pkg::CMD_OFS, 32'h0000_0001);
    wait_idle();
  endtask
  // Duration covers any wait for a device write still in progress
  task automatic ee_read(input logic [9:0] a, output logic [7:0] b, output int dur);
    int t0;
    logic [31:0] q;
    wr(eeba_pkg::ADDR_OFS, {22'h00_0000, a});
    t0 = cyc;
    wr(eeba_pkg::CMD_OFS, 32'h0000_0002);
    wait_idle();
    dur = cyc - t0;
    apb(1'b0, eeba_pkg::STAT_OFS, 32'h0000_0000, q);
    b = q[15:8];
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] b;
    logic [7:0] old;
    int dur;
    presetn = 1'b0;
    clk_en = 1'b1;
    core_rst = 1'b0;
    rc_tick = 1'b1;
    self_prog_busy = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_mismatch = 0;
    samples_checked = 0;
    old = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(eeba_pkg::STAT_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(eeba_pkg::CFG_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rd_chk(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(eeba_pkg::CFG_OFS, {28'h000_0000, md[i], 2'h0});
      ee_write(10'h3FF, wd[i]);
      case (md[i])
        eeba_pkg::PM_ATOMIC: old = wd[i];
        eeba_pkg::PM_ERASE: old = eeba_pkg::ERASED_BYTE;
        eeba_pkg::PM_WRITE: old = old & wd[i];
        default: ;
      endcase
      ee_read(10'h3FF, b, dur);
      chk({24'h00_0000, b}, {24'h00_0000, old});
      chk({31'h0000_0000, dur >= lo[i] && dur < hi[i]}, 32'h0000_0001);
    end
    wr(eeba_pkg::CFG_OFS, 32'h0000_0003);
    // The ready enable reaches the device only with the next control write, so run a read first
    ee_read(10'h3FF, b, dur);
    chk({24'h00_0000, b}, {24'h00_0000, old});
    repeat (4) @(posedge pclk);
    rd_chk(eeba_pkg::STAT_OFS, 32'h0000_0004, 32'h0000_0004);
    self_prog_busy <= 1'b1;
    wr(eeba_pkg::ADDR_OFS, 32'h0000_0000);
    wr(eeba_pkg::WDAT_OFS, 32'h0000_0011);
    wr(eeba_pkg::CMD_OFS, 32'h0000_0001);
    repeat (60) @(posedge pclk);
    rd_chk(eeba_pkg::STAT_OFS, 32'h0000_0007, 32'h0000_0001);
    self_prog_busy <= 1'b0;
    wait_idle();
    rd_chk(eeba_pkg::STAT_OFS, 32'h0000_0004, 32'h0000_0000);
    ee_read(10'h000, b, dur);
    chk({24'h00_0000, b}, 32'h0000_0011);
    rd_chk(eeba_pkg::STAT_OFS, 32'h0000_0004, 32'h0000_0004);
    wr(eeba_pkg::CFG_OFS, 32'h0000_0006);
    repeat (4) @(posedge pclk);
    rd_chk(eeba_pkg::STAT_OFS, 32'h0000_0004, 32'h0000_0000);
    ee_write(10'h000, 8'h00);
    core_rst <= 1'b1;
    @(posedge pclk);
    core_rst <= 1'b0;
    ee_read(10'h000, b, dur);
    chk({24'h00_0000, b}, {24'h00_0000, eeba_pkg::ERASED_BYTE});
    chk({31'h0000_0000, dur >= 60 && dur < 150}, 32'h0000_0001);
    tally_and_finish();
  end
endmodule
`default_nettype wire
